//--- src/hks_pkg.sv
// Package for the hex keypad matrix scanner: register map, fields, timing
package hks_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] VALUE_OFF = 8'h04;
  localparam logic [7:0] KEYSTAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
  localparam logic [7:0] SCAN_DIV_OFF = 8'h14;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HEX_BIT = 1;
  localparam int CTRL_WIDE_BIT = 2;
  localparam int CTRL_CLR_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // ----------------------------------------------------------------
  // Key status layout and interrupt events
  // ----------------------------------------------------------------
  localparam int KS_LETTER_EVT = 6;
  localparam int KS_DIGIT_EVT = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LETTER_BIT = 1;
  localparam int IRQ_DIGIT_BIT = 2;
  // ----------------------------------------------------------------
  // Limits and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] MAX_NARROW = 32'h0000_270f;
  localparam logic [31:0] MOD_NARROW = 32'h0000_2710;
  localparam logic [31:0] MAX_WIDE = 32'h05f5_e0ff;
  localparam logic [31:0] MOD_WIDE = 32'h05f5_e100;
  localparam int SCANS_PER_READ = 8;
  localparam int SCAN_TICK_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCAN_TICK_CYC = SCAN_TICK_NS / CLK_PERIOD_NS;
  localparam logic [15:0] SCAN_DIV_RST = 16'(SCAN_TICK_CYC);
  // ----------------------------------------------------------------
  // Scan state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SCAN = 3'b010,
    ST_HOLD = 3'b100
  } hks_state_e;
endpackage : hks_pkg

//--- src/hks_scanner.sv
// Hex keypad matrix scanner with AHB-Lite register slave
//
// Our own choices: the register offsets and register access over AHB-Lite.
module hks_scanner
  import hks_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Keypad matrix
  output logic [3:0] ROW_OUTPUT_POINTS,
  input wire logic [3:0] COL_IN,
  // Status
  output logic COMPLETION_FLAG,
  output logic [7:0] KEY_STATUS_BITS,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic [15:0] scan_div_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [31:0] key_value_register_r;
  logic [7:0] key_status_r;
  logic done_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [3:0] col_s1_r;
  logic [3:0] col_s2_r;
  logic [15:0] div_cnt_r;
  logic tick_r;
  logic enable;
  assign enable = ctrl_r[CTRL_EN_BIT];
  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  logic take;
  assign take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && HWRITE;
      wr_addr_r <= HADDR[7:0];
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      HRDATA <= 32'h0;
    end else if (take && !HWRITE) begin
      if (HADDR[7:0] == CTRL_OFF) begin
        HRDATA <= {28'h0, ctrl_r};
      end else if (HADDR[7:0] == VALUE_OFF) begin
        HRDATA <= key_value_register_r;
      end else if (HADDR[7:0] == KEYSTAT_OFF) begin
        HRDATA <= {24'h0, key_status_r};
      end else if (HADDR[7:0] == IRQ_STAT_OFF) begin
        HRDATA <= {29'h0, irq_stat_r};
      end else if (HADDR[7:0] == IRQ_MASK_OFF) begin
        HRDATA <= {29'h0, irq_mask_r};
      end else if (HADDR[7:0] == SCAN_DIV_OFF) begin
        HRDATA <= {16'h0, scan_div_r};
      end else begin
        HRDATA <= 32'h0;
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end
  logic wr_ctrl, wr_mask, wr_div, wr_istat, clr_value;
  assign wr_ctrl = wr_pend_r && (wr_addr_r == CTRL_OFF);
  assign wr_mask = wr_pend_r && (wr_addr_r == IRQ_MASK_OFF);
  assign wr_div = wr_pend_r && (wr_addr_r == SCAN_DIV_OFF);
  assign wr_istat = wr_pend_r && (wr_addr_r == IRQ_STAT_OFF);
  assign clr_value = wr_ctrl && HWDATA[CTRL_CLR_BIT];
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctrl_r <= CTRL_RST;
      irq_mask_r <= 3'h0;
      scan_div_r <= SCAN_DIV_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= {1'b0, HWDATA[2:0]};
      if (wr_mask) irq_mask_r <= HWDATA[2:0];
      if (wr_div) scan_div_r <= (HWDATA[15:0] == 16'h0) ? 16'h1 : HWDATA[15:0];
    end
  end
  // ----------------------------------------------------------------
  // Column synchroniser and scan tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      col_s1_r <= 4'h0;
      col_s2_r <= 4'h0;
    end else begin
      col_s1_r <= COL_IN;
      col_s2_r <= col_s1_r;
    end
  end
  // A divider programmed through scan_div_r gives the regular scan interval the matrix wiring expects
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !enable) begin
      div_cnt_r <= 16'h0;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= scan_div_r - 16'h1) begin
      div_cnt_r <= 16'h0;
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h1;
      tick_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Matrix scan: rows 0..3 twice make the eight-step read
  // ----------------------------------------------------------------
  hks_state_e state_r;
  logic [2:0] step_r;
  logic found_r;
  logic [3:0] found_key_r;
  logic [3:0] held_key_r;
  logic held_r;
  logic held_seen_r;
  logic [1:0] row_idx;
  logic [1:0] col_idx;
  logic col_any;
  assign row_idx = step_r[1:0];
  assign col_any = |col_s2_r;
  always_comb begin
    col_idx = 2'd0;
    // Lowest column wins when several are down in one row
    for (int i = 3; i >= 0; i--) begin
      if (col_s2_r[i]) col_idx = 2'(i);
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !enable) begin
      ROW_OUTPUT_POINTS <= 4'h0;
    end else begin
      ROW_OUTPUT_POINTS <= 4'h1 << row_idx;
    end
  end
  logic accept_r;
  logic [3:0] acc_key_r;
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !enable) begin
      state_r <= ST_IDLE;
      step_r <= 3'd0;
      found_r <= 1'b0;
      found_key_r <= 4'h0;
      held_r <= 1'b0;
      held_seen_r <= 1'b0;
      held_key_r <= 4'h0;
      accept_r <= 1'b0;
      acc_key_r <= 4'h0;
    end else begin
      accept_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          step_r <= 3'd0;
          found_r <= 1'b0;
          held_seen_r <= 1'b0;
          if (tick_r) state_r <= ST_SCAN;
        end
        ST_SCAN: begin
          if (tick_r) begin
            // Row set one tick earlier, so columns have settled; a divider
            // below four lets the row outrun the column synchroniser
            if (col_any && !found_r) begin
              found_r <= 1'b1;
              found_key_r <= {row_idx, col_idx};
            end
            if (held_r && row_idx == held_key_r[3:2] && col_s2_r[held_key_r[1:0]]) begin
              held_seen_r <= 1'b1;
            end
            step_r <= step_r + 3'd1;
            if (step_r == 3'(SCANS_PER_READ - 1)) state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // While the held key stays down every later key is ignored
          if (!(held_r && held_seen_r)) begin
            if (found_r) begin
              accept_r <= 1'b1;
              acc_key_r <= found_key_r;
              held_key_r <= found_key_r;
            end
            held_r <= found_r;
          end
          held_seen_r <= 1'b0;
          step_r <= 3'd0;
          found_r <= 1'b0;
          state_r <= ST_SCAN;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Value accumulation
  // ----------------------------------------------------------------
  logic hex_mode, wide;
  logic is_digit;
  logic [31:0] value_mod;
  logic [31:0] value_nxt;
  assign hex_mode = ctrl_r[CTRL_HEX_BIT];
  assign wide = ctrl_r[CTRL_WIDE_BIT];
  assign is_digit = acc_key_r < 4'ha;
  always_comb begin
    // Drop the top digit first so the decimal shift never leaves range; a hex shift that does is wrapped below
    value_mod = wide ? key_value_register_r % (MOD_WIDE / 32'd10)
                     : key_value_register_r % (MOD_NARROW / 32'd10);
    if (hex_mode) begin
      value_nxt = value_mod * 32'd16 + {28'h0, acc_key_r};
    end else begin
      value_nxt = value_mod * 32'd10 + {28'h0, acc_key_r};
    end
    if (!wide && value_nxt > MAX_NARROW) value_nxt = value_nxt % MOD_NARROW;
    if (wide && value_nxt > MAX_WIDE) value_nxt = value_nxt % MOD_WIDE;
  end
  // Value survives enable low; only reset or software clear zero it
  always_ff @(posedge SYS_CLK) begin
    if (SRST || clr_value) begin
      key_value_register_r <= 32'h0;
    end else if (accept_r && (is_digit || hex_mode)) begin
      key_value_register_r <= value_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Key status, completion and events
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !enable) begin
      key_status_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      key_status_r[KS_LETTER_EVT] <= 1'b0;
      key_status_r[KS_DIGIT_EVT] <= 1'b0;
      if (accept_r) begin
        done_r <= 1'b1;
        if (is_digit) begin
          key_status_r[KS_DIGIT_EVT] <= 1'b1;
        end else begin
          key_status_r[KS_LETTER_EVT] <= 1'b1;
          if (!hex_mode) begin
            key_status_r[5:0] <= 6'h01 << 3'(acc_key_r - 4'ha);
          end
        end
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      COMPLETION_FLAG <= 1'b0;
      KEY_STATUS_BITS <= 8'h00;
    end else begin
      COMPLETION_FLAG <= done_r;
      KEY_STATUS_BITS <= key_status_r;
    end
  end
  // ----------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set = {key_status_r[KS_DIGIT_EVT], key_status_r[KS_LETTER_EVT], done_r};
  assign irq_clr = wr_istat ? HWDATA[2:0] : 3'h0;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      irq_stat_r <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      IRQ <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end
endmodule : hks_scanner

//--- verif/hks_keymat.sv
// Passive 4x4 switch matrix, key index is row * 4 + column
module hks_keymat (
  // Matrix lines
  input wire logic [3:0] rows,
  input wire logic [15:0] keys,
  output logic [3:0] cols
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven columns sit at their pull-down level
  always_comb begin
    cols = 4'h0;
    for (int r = 0; r < 4; r++) begin
      if (rows[r]) cols |= keys[r*4 +: 4];
    end
  end
endmodule : hks_keymat

//--- verif/hks_scanner_properties.sv
// Port-level assertions for the keypad scanner
module hks_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Observed outputs
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [3:0] ROW_OUTPUT_POINTS,
  input wire logic COMPLETION_FLAG,
  input wire logic [7:0] KEY_STATUS_BITS,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_bus_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  chk_zero_wait: assert property (!$past(SRST) |-> HREADYOUT)
    else $error("slave inserted a wait state");
  chk_row_single: assert property ($onehot0(ROW_OUTPUT_POINTS))
    else $error("more than one row driven");
  chk_flag_pulse: assert property (COMPLETION_FLAG |=> !COMPLETION_FLAG [*8])
    else $error("completion flag not a lone pulse");
  chk_letter_pulse: assert property (KEY_STATUS_BITS[6] |=> !KEY_STATUS_BITS[6] [*8])
    else $error("letter event not a lone pulse");
  chk_digit_pulse: assert property (KEY_STATUS_BITS[7] |=> !KEY_STATUS_BITS[7] [*8])
    else $error("digit event not a lone pulse");
  chk_evt_exclusive: assert property (!(KEY_STATUS_BITS[6] && KEY_STATUS_BITS[7]))
    else $error("letter and digit events together");
  chk_held_single: assert property ($onehot0(KEY_STATUS_BITS[5:0]))
    else $error("several letter bits held");
  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  cov_flag: cover property (COMPLETION_FLAG);
  cov_letter: cover property (KEY_STATUS_BITS[6]);
  cov_digit: cover property (KEY_STATUS_BITS[7]);
  cov_irq: cover property ($rose(IRQ));
endmodule : hks_chk

bind hks_scanner hks_chk chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .ROW_OUTPUT_POINTS(ROW_OUTPUT_POINTS), .COMPLETION_FLAG(COMPLETION_FLAG),
  .KEY_STATUS_BITS(KEY_STATUS_BITS), .IRQ(IRQ));

//--- verif/tb_top.sv
// Self-checking bench for the keypad scanner
module tb_top import hks_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 0, SRST = 1, HSEL = 0, HWRITE = 0, HREADY;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, v;
  logic HREADYOUT, HRESP, COMPLETION_FLAG, IRQ;
  logic [3:0] ROW_OUTPUT_POINTS, COL_IN, d;
  logic [7:0] KEY_STATUS_BITS, ks;
  logic [15:0] keys_down = 16'h0;
  logic [1:0] ev;
  int n_mismatch = 0, compares = 0, cyc = 0, i;
  assign HREADY = HREADYOUT;
  always #4 SYS_CLK = ~SYS_CLK;
  hks_scanner dut_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .ROW_OUTPUT_POINTS(ROW_OUTPUT_POINTS), .COL_IN(COL_IN),
    .COMPLETION_FLAG(COMPLETION_FLAG), .KEY_STATUS_BITS(KEY_STATUS_BITS), .IRQ(IRQ));
  hks_keymat mat_u (.rows(ROW_OUTPUT_POINTS), .keys(keys_down), .cols(COL_IN));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp, "register read");
  endtask : rdchk
  // Holds keys until accepted, adds the late keys for about three reads,
  // then releases long enough for a full empty read
  task automatic press(input logic [15:0] m, input logic [15:0] late);
    int k;
    logic f;
    f = 1'b0;
    ev = 2'h0;
    @(posedge SYS_CLK);
    keys_down <= m;
    for (k = 0; k < 400 && f !== 1'b1; k++) begin
      @(posedge SYS_CLK);
      ev |= KEY_STATUS_BITS[7:6];
      f = COMPLETION_FLAG;
    end
    repeat (3) begin
      @(posedge SYS_CLK);
      ev |= KEY_STATUS_BITS[7:6];
    end
    check(32'(f), 32'h1, "no completion");
    keys_down <= m | late;
    f = 1'b0;
    repeat (100) begin
      @(posedge SYS_CLK);
      f |= COMPLETION_FLAG;
    end
    keys_down <= 16'h0;
    check(32'(f), 32'h0, "held or late key accepted");
    repeat (100) @(posedge SYS_CLK);
    ks = KEY_STATUS_BITS;
  endtask : press
  function automatic logic [31:0] nxt(input logic [31:0] x, input logic [3:0] g, input logic w);
    logic [31:0] lim;
    lim = w ? MOD_WIDE : MOD_NARROW;
    return (x % (lim / 10)) * 10 + 32'(g);
  endfunction : nxt
  task automatic digits(input int n, input logic w);
    for (i = 0; i < n; i++) begin
      d = 4'($urandom_range(9));
      press(16'h1 << d, 16'h0);
      check(32'(ev), 32'h2, "digit event");
      v = nxt(v, d, w);
      rdchk(VALUE_OFF, v);
    end
  endtask : digits
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(58033));
    v = 32'h0;
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rdchk(CTRL_OFF, {28'h0, CTRL_RST});
    rdchk(SCAN_DIV_OFF, {16'h0, SCAN_DIV_RST});
    bus(1'b1, VALUE_OFF, 32'h1234);
    rdchk(VALUE_OFF, 32'h0);
    rdchk(8'h40, 32'h0);
    check(32'(ROW_OUTPUT_POINTS), 32'h0, "rows while off");
    // Four clocks a tick let each row settle through the column synchroniser
    bus(1'b1, SCAN_DIV_OFF, 32'h4);
    rdchk(SCAN_DIV_OFF, 32'h4);
    bus(1'b1, IRQ_MASK_OFF, 32'h7);
    bus(1'b1, CTRL_OFF, 32'h1);
    $display("test registers done");
    digits(6, 1'b0);
    $display("test narrow digits done");
    for (i = 10; i < 16; i++) begin
      press(16'h1 << i, 16'h0);
      check(32'(ev), 32'h1, "letter event");
      check(32'(ks[5:0]), 32'h1 << (i - 10), "held letter");
    end
    rdchk(VALUE_OFF, v);
    // Key nine is taken first; key three joins while nine is down
    press(16'h1 << 9, 16'h1 << 3);
    v = nxt(v, 4'h9, 1'b0);
    rdchk(VALUE_OFF, v);
    $display("test letters and two keys done");
    bus(1'b1, CTRL_OFF, 32'h5);
    digits(9, 1'b1);
    $display("test wide digits done");
    bus(1'b1, CTRL_OFF, 32'h8);
    bus(1'b1, CTRL_OFF, 32'h7);
    press(16'h1 << 10, 16'h0);
    check(32'(ev), 32'h1, "hex letter event");
    check(32'(ks[5:0]), 32'h0, "hex held bits");
    press(16'h1 << 5, 16'h0);
    rdchk(VALUE_OFF, 32'ha5);
    v = 32'ha5;
    $display("test hex entry done");
    bus(1'b1, CTRL_OFF, 32'h0);
    repeat (4) @(posedge SYS_CLK);
    check(32'(KEY_STATUS_BITS), 32'h0, "status after disable");
    check(32'(ROW_OUTPUT_POINTS), 32'h0, "rows after disable");
    rdchk(VALUE_OFF, v);
    $display("test disable done");
    rdchk(IRQ_STAT_OFF, 32'h7);
    check(32'(IRQ), 32'h1, "irq raised");
    bus(1'b1, IRQ_MASK_OFF, 32'h0);
    repeat (2) @(posedge SYS_CLK);
    check(32'(IRQ), 32'h0, "irq masked");
    bus(1'b1, IRQ_MASK_OFF, 32'h7);
    bus(1'b1, IRQ_STAT_OFF, 32'h2);
    rdchk(IRQ_STAT_OFF, 32'h5);
    bus(1'b1, IRQ_STAT_OFF, 32'h5);
    rdchk(IRQ_STAT_OFF, 32'h0);
    repeat (2) @(posedge SYS_CLK);
    check(32'(IRQ), 32'h0, "irq cleared");
    $display("test interrupts done");
    give_verdict();
  end
endmodule : tb_top
